// ### rtl/fbw_pkg.sv
package fbw_pkg;
    // Register byte offsets
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
    localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
    localparam logic [7:0] DATA_LOW_OFS = 8'h08;
    localparam logic [7:0] DATA_HIGH_OFS = 8'h0c;
    localparam logic [7:0] CONTROL_OFS = 8'h10;
    localparam logic [7:0] UNLOCK_KEY_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // Control fields
    localparam int CTRL_PGM_SEL_BIT = 7;
    localparam int CTRL_TRIGGER_BIT = 1;
    localparam int CTRL_READ_BIT = 0;
    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_IDX_LSB = 2;
    localparam int STAT_IGNORED_BIT = 4;
    // Unlock keys and sequencing
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [1:0] KEY_NONE = 2'h0;
    localparam logic [1:0] KEY_HALF = 2'h1;
    localparam logic [1:0] KEY_ARMED = 2'h2;
    localparam logic [1:0] FIRST_WORD = 2'h0;
    localparam logic [1:0] LAST_WORD = 2'h3;
    // Write protect selection and limits (addresses below limit protected)
    localparam logic [1:0] WP_OFF = 2'h3;
    localparam logic [1:0] WP_LOW = 2'h2;
    localparam logic [1:0] WP_HALF = 2'h1;
    localparam int WP_LOW_LIMIT = 32'h0000_0100;
    localparam int WP_HALF_LIMIT = 32'h0000_0800;
    localparam int WP_ALL_LIMIT = 32'h0001_0000;
    // Timing
    localparam int CLOCK_MHZ = 250;
    localparam int SETUP_CYCLES = 2;
    localparam int WRITE_TIME_MS = 4;
    localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000 * CLOCK_MHZ;
    localparam int CNT_W = 24;
    localparam logic [1:0] RESET_WP = 2'h3;
    typedef enum logic [1:0] {FBW_IDLE, FBW_SETUP, FBW_ERASE, FBW_PROG} fbw_phase_t;
endpackage

// ### rtl/fbw_sequencer.sv
// Functional notes
// - Write only outside write-protected segments
// - Program only aligned four-word sequential blocks
// - Each block erased then written, never crossing
// - Select memory, key 55h then AAh, trigger
// - Last word triggers block erase and program
// - Two setup cycles after trigger
// - First three words buffer without stall
// - Core halts about 4 ms, clocks run
// - Core resumes once write finishes
// - Invalid location sequence is ignored
module fbw_sequencer import fbw_pkg::*; #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 14,
    parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Configuration word
    input wire logic [1:0] writeProtectSelect,
    // Flash array port
    output logic [ADDR_W-1:0] flashAddr,
    output logic [DATA_W-1:0] flashWdata,
    output logic flashErase,
    output logic flashProgram,
    output logic flashRead,
    input wire logic [DATA_W-1:0] flashRdata,
    // Core
    output logic coreStall
);
    if (ADDR_W < 9 || ADDR_W > 16 || DATA_W < 9 || DATA_W > 16) begin : g_widthCheck
        $error("fbw_sequencer: address or data width out of range");
    end
    if (WRITE_CYCLES_P < 16 || WRITE_CYCLES_P >= (1 << CNT_W)) begin : g_countCheck
        $error("fbw_sequencer: write cycle count out of range");
    end

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic pgmSel;
        logic trig;
        logic rdWait;
        logic [1:0] key;
        logic [1:0] wordIdx;
        logic [ADDR_W-3:0] blockBase;
        logic [3:0][DATA_W-1:0] wordBuf;
        fbw_phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic [1:0] progIdx;
        logic ignored;
        logic [31:0] rdata;
        logic err;
        logic [ADDR_W-1:0] fAddr;
        logic [DATA_W-1:0] fData;
        logic fErase;
        logic fProg;
        logic fRead;
    } fbw_state_t;

    fbw_state_t r;
    fbw_state_t next_r;

    function automatic logic isProtected(input logic [1:0] sel, input logic [ADDR_W-1:0] a);
        int lim;
        case (sel)
            WP_OFF: lim = 0;
            WP_LOW: lim = WP_LOW_LIMIT;
            WP_HALF: lim = WP_HALF_LIMIT;
            default: lim = WP_ALL_LIMIT;
        endcase
        return 32'(a) < lim;
    endfunction

    // Access decode
    logic setupPh;
    logic access;
    logic wrAccess;
    logic ctrlWrite;
    logic trigWrite;
    logic locOk;
    logic accept;
    logic bufAccept;
    logic lastAccept;

    assign setupPh = psel && !penable;
    assign access = psel && penable;
    assign wrAccess = access && pwrite;
    assign ctrlWrite = wrAccess && paddr == CONTROL_OFS;
    assign trigWrite = ctrlWrite && pwdata[CTRL_TRIGGER_BIT];
    // Aligned, ascending, same block, unprotected
    assign locOk = r.addr[1:0] == r.wordIdx
        && (r.wordIdx == FIRST_WORD || r.addr[ADDR_W-1:2] == r.blockBase)
        && !isProtected(writeProtectSelect, r.addr);
    assign accept = trigWrite && r.key == KEY_ARMED && pwdata[CTRL_PGM_SEL_BIT]
        && r.phase == FBW_IDLE && !r.rdWait && locOk;
    assign bufAccept = accept && r.wordIdx != LAST_WORD;
    assign lastAccept = accept && r.wordIdx == LAST_WORD;

    assign pready = 1'b1;
    assign prdata = r.rdata;
    assign pslverr = r.err;
    assign flashAddr = r.fAddr;
    assign flashWdata = r.fData;
    assign flashErase = r.fErase;
    assign flashProgram = r.fProg;
    assign flashRead = r.fRead;
    assign coreStall = r.phase == FBW_ERASE || r.phase == FBW_PROG;

    always_comb begin
        next_r = r;
        next_r.fErase = 1'b0;
        next_r.fProg = 1'b0;
        next_r.fRead = 1'b0;

        // Read data prepared in setup phase
        if (setupPh) begin
            next_r.rdata = 32'h0000_0000;
            next_r.err = 1'b0;
            case (paddr)
                ADDR_LOW_OFS: next_r.rdata[7:0] = r.addr[7:0];
                ADDR_HIGH_OFS: next_r.rdata[ADDR_W-9:0] = r.addr[ADDR_W-1:8];
                DATA_LOW_OFS: next_r.rdata[7:0] = r.data[7:0];
                DATA_HIGH_OFS: next_r.rdata[DATA_W-9:0] = r.data[DATA_W-1:8];
                CONTROL_OFS: begin
                    next_r.rdata[CTRL_PGM_SEL_BIT] = r.pgmSel;
                    next_r.rdata[CTRL_TRIGGER_BIT] = r.trig;
                    next_r.rdata[CTRL_READ_BIT] = r.rdWait;
                end
                UNLOCK_KEY_OFS: next_r.rdata = 32'h0000_0000;
                STATUS_OFS: begin
                    next_r.rdata[STAT_BUSY_BIT] = r.phase != FBW_IDLE;
                    next_r.rdata[STAT_ARMED_BIT] = r.key == KEY_ARMED;
                    next_r.rdata[STAT_IDX_LSB +: 2] = r.wordIdx;
                    next_r.rdata[STAT_IGNORED_BIT] = r.ignored;
                end
                default: next_r.err = 1'b1;
            endcase
        end

        // Unlock tracking: any other access cancels
        if (access) begin
            next_r.key = KEY_NONE;
            if (wrAccess && paddr == UNLOCK_KEY_OFS) begin
                if (pwdata[7:0] == KEY_FIRST) begin
                    next_r.key = KEY_HALF;
                end else if (pwdata[7:0] == KEY_SECOND && r.key == KEY_HALF) begin
                    next_r.key = KEY_ARMED;
                end
            end
        end

        // Register writes
        if (wrAccess) begin
            case (paddr)
                ADDR_LOW_OFS: next_r.addr[7:0] = pwdata[7:0];
                ADDR_HIGH_OFS: next_r.addr[ADDR_W-1:8] = pwdata[ADDR_W-9:0];
                DATA_LOW_OFS: next_r.data[7:0] = pwdata[7:0];
                DATA_HIGH_OFS: next_r.data[DATA_W-1:8] = pwdata[DATA_W-9:0];
                CONTROL_OFS: next_r.pgmSel = pwdata[CTRL_PGM_SEL_BIT];
                default: next_r.err = r.err;
            endcase
        end

        // Program memory read into data registers
        if (ctrlWrite && pwdata[CTRL_READ_BIT] && !trigWrite
                && r.phase == FBW_IDLE && !r.rdWait) begin
            next_r.rdWait = 1'b1;
            next_r.fRead = 1'b1;
            next_r.fAddr = r.addr;
        end
        if (r.rdWait && !r.fRead) begin
            next_r.rdWait = 1'b0;
            next_r.data = flashRdata;
        end

        // Trigger handling
        if (trigWrite && !accept && r.phase == FBW_IDLE) begin
            next_r.ignored = 1'b1;
        end
        if (accept) begin
            next_r.ignored = 1'b0;
            next_r.wordBuf[r.wordIdx] = r.data;
            if (r.wordIdx == FIRST_WORD) begin
                next_r.blockBase = r.addr[ADDR_W-1:2];
            end
            if (bufAccept) begin
                next_r.wordIdx = 2'(r.wordIdx + 2'h1);
                next_r.trig = 1'b0;
            end else begin
                next_r.trig = 1'b1;
                next_r.phase = FBW_SETUP;
                next_r.cnt = CNT_W'(SETUP_CYCLES - 1);
            end
        end

        // Block erase and program
        case (r.phase)
            FBW_IDLE: next_r.progIdx = FIRST_WORD;
            FBW_SETUP: begin
                next_r.cnt = CNT_W'(r.cnt - 1'b1);
                if (r.cnt == '0) begin
                    next_r.phase = FBW_ERASE;
                    next_r.fErase = 1'b1;
                    next_r.fAddr = {r.blockBase, FIRST_WORD};
                    next_r.cnt = CNT_W'(WRITE_CYCLES_P - 1);
                end
            end
            FBW_ERASE: begin
                next_r.cnt = CNT_W'(r.cnt - 1'b1);
                if (r.cnt == '0) begin
                    next_r.phase = FBW_PROG;
                    next_r.fProg = 1'b1;
                    next_r.fAddr = {r.blockBase, FIRST_WORD};
                    next_r.fData = r.wordBuf[FIRST_WORD];
                    next_r.progIdx = FIRST_WORD;
                end
            end
            FBW_PROG: begin
                if (r.progIdx == LAST_WORD) begin
                    next_r.phase = FBW_IDLE;
                    next_r.trig = 1'b0;
                    next_r.wordIdx = FIRST_WORD;
                end else begin
                    next_r.progIdx = 2'(r.progIdx + 2'h1);
                    next_r.fProg = 1'b1;
                    next_r.fAddr = {r.blockBase, 2'(r.progIdx + 2'h1)};
                    next_r.fData = r.wordBuf[2'(r.progIdx + 2'h1)];
                end
            end
            default: next_r.phase = FBW_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.phase <= FBW_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Checks
    property p_lastSetup;
        @(posedge clock) disable iff (reset)
        lastAccept |=> !coreStall [*2] ##1 (coreStall && flashErase);
    endproperty
    a_lastSetup: assert property (p_lastSetup) else $error("erase not after two setup cycles");

    property p_bufNoStall;
        @(posedge clock) disable iff (reset)
        bufAccept |=> !coreStall [*3];
    endproperty
    a_bufNoStall: assert property (p_bufNoStall) else $error("buffered word stalled core");

    property p_eraseFirst;
        @(posedge clock) disable iff (reset)
        flashErase |-> flashAddr[1:0] == FIRST_WORD ##1 (!flashProgram && coreStall) [*8];
    endproperty
    a_eraseFirst: assert property (p_eraseFirst) else $error("erase misaligned or cut short");

    property p_protect;
        @(posedge clock) disable iff (reset)
        flashErase |-> !isProtected(writeProtectSelect, flashAddr);
    endproperty
    a_protect: assert property (p_protect) else $error("protected segment erased");

    property p_progOrder;
        @(posedge clock) disable iff (reset)
        flashProgram && flashAddr[1:0] == FIRST_WORD |=>
            flashProgram && flashAddr[1:0] == 2'h1 ##1 flashProgram ##1
            (flashProgram && flashAddr[1:0] == LAST_WORD) ##1 !coreStall;
    endproperty
    a_progOrder: assert property (p_progOrder) else $error("block program order wrong");

    property p_keyCancel;
        @(posedge clock) disable iff (reset)
        r.key == KEY_ARMED && access && !ctrlWrite
            && !(wrAccess && paddr == UNLOCK_KEY_OFS && pwdata[7:0] == KEY_FIRST)
            |=> r.key == KEY_NONE;
    endproperty
    a_keyCancel: assert property (p_keyCancel) else $error("unlock survived other access");

    property p_ignore;
        @(posedge clock) disable iff (reset)
        trigWrite && !accept && r.phase == FBW_IDLE |=> r.ignored && !coreStall && !r.trig;
    endproperty
    a_ignore: assert property (p_ignore) else $error("invalid trigger not ignored");

    property p_trigClear;
        @(posedge clock) disable iff (reset)
        $fell(coreStall) |-> !r.trig && $past(flashProgram);
    endproperty
    a_trigClear: assert property (p_trigClear) else $error("trigger not cleared at end");

    property p_keyOrder;
        @(posedge clock) disable iff (reset)
        wrAccess && paddr == UNLOCK_KEY_OFS && pwdata[7:0] == KEY_SECOND
            && r.key != KEY_HALF |=> r.key == KEY_NONE;
    endproperty
    a_keyOrder: assert property (p_keyOrder) else $error("second key armed out of order");

    property p_trigHeld;
        @(posedge clock) disable iff (reset)
        coreStall |-> r.trig;
    endproperty
    a_trigHeld: assert property (p_trigHeld) else $error("trigger dropped early");

    property p_idxReset;
        @(posedge clock) disable iff (reset)
        $fell(coreStall) |-> r.wordIdx == FIRST_WORD && r.phase == FBW_IDLE;
    endproperty
    a_idxReset: assert property (p_idxReset) else $error("index not reset");

    property p_refusedKeep;
        @(posedge clock) disable iff (reset)
        trigWrite && !accept && r.phase == FBW_IDLE |=>
            $stable(r.wordIdx) && $stable(r.wordBuf) && $stable(r.blockBase);
    endproperty
    a_refusedKeep: assert property (p_refusedKeep) else $error("buffer changed");

    property p_bufAdvance;
        @(posedge clock) disable iff (reset)
        bufAccept |=> r.wordIdx == 2'($past(r.wordIdx) + 2'h1) && !r.trig;
    endproperty
    a_bufAdvance: assert property (p_bufAdvance) else $error("index not advanced");

    c_buffered: cover property (@(posedge clock) disable iff (reset) bufAccept);
    c_block: cover property (@(posedge clock) disable iff (reset) lastAccept);
    c_ignored: cover property (@(posedge clock) disable iff (reset) $rose(r.ignored));
    c_resume: cover property (@(posedge clock) disable iff (reset) $fell(coreStall));
    c_arrayRead: cover property (@(posedge clock) disable iff (reset) flashRead);
endmodule

// ### verification/flash_block_write_sequencer_test.sv
module flash_block_write_sequencer_test import fbw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WC = 16;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} fbw_row_t;
    typedef struct {logic [1:0] sel; logic [12:0] addr; logic [31:0] q;} fbw_wp_t;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, flashErase, flashProgram, flashRead, coreStall;
    logic [1:0] writeProtectSelect = WP_OFF;
    logic [12:0] flashAddr, eraseAddr;
    logic [13:0] flashWdata, flashRdata = 14'h0;
    logic [12:0] progAddr[4];
    logic [13:0] progData[4];
    int n_mismatch = 0, n_checks = 0, nProg = 0, nErase = 0, stallCnt = 0;
    fbw_row_t rows[7] = '{'{ADDR_LOW_OFS, 32'ha5, 32'ha5, 1'b0},
        '{ADDR_HIGH_OFS, 32'hff, 32'h1f, 1'b0}, '{DATA_LOW_OFS, 32'h3c, 32'h3c, 1'b0},
        '{DATA_HIGH_OFS, 32'hff, 32'h3f, 1'b0}, '{UNLOCK_KEY_OFS, 32'h0, 32'h0, 1'b0},
        '{CONTROL_OFS, 32'h80, 32'h80, 1'b0}, '{8'h1c, 32'hff, 32'h0, 1'b1}};
    fbw_wp_t wps[6] = '{'{2'h3, 13'h0040, 32'h04}, '{2'h2, 13'h00fc, 32'h10},
        '{2'h2, 13'h0100, 32'h04}, '{2'h1, 13'h07fc, 32'h10},
        '{2'h1, 13'h0800, 32'h04}, '{2'h0, 13'h1000, 32'h10}};

    always #2 clock = ~clock;

    fbw_sequencer #(.WRITE_CYCLES_P(WC)) u_dut (.clock(clock), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .writeProtectSelect(writeProtectSelect),
        .flashAddr(flashAddr), .flashWdata(flashWdata), .flashErase(flashErase),
        .flashProgram(flashProgram), .flashRead(flashRead), .flashRdata(flashRdata),
        .coreStall(coreStall));

    // Flash array read model
    always @(posedge clock) begin
        if (flashRead === 1'b1) flashRdata <= 14'h2a5a ^ 14'(flashAddr);
    end

    // Flash activity monitor
    always @(negedge clock) begin
        if (flashProgram === 1'b1) begin
            if (nProg < 4) begin
                progAddr[nProg] = flashAddr;
                progData[nProg] = flashWdata;
            end
            nProg++;
        end
        if (flashErase === 1'b1) begin
            eraseAddr = flashAddr;
            nErase++;
        end
        if (coreStall === 1'b1) stallCnt++;
    end

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
            $display("Error at %0t: no pready", $time);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] q,
        input string msg);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r & m, q, msg);
    endtask

    // Kind 0 good, 1 no unlock, 2 access between keys, 3 select clear, 4 keys swapped,
    // 5 access after keys
    task automatic seq(input logic [12:0] ad, input logic [13:0] dt, input int kind);
        wr(ADDR_LOW_OFS, 32'(ad[7:0]));
        wr(ADDR_HIGH_OFS, 32'(ad[12:8]));
        wr(DATA_LOW_OFS, 32'(dt[7:0]));
        wr(DATA_HIGH_OFS, 32'(dt[13:8]));
        if (kind != 1) wr(UNLOCK_KEY_OFS, 32'(kind == 4 ? KEY_SECOND : KEY_FIRST));
        if (kind == 2) rchk(STATUS_OFS, 32'h02, 32'h0, "between");
        if (kind != 1) wr(UNLOCK_KEY_OFS, 32'(kind == 4 ? KEY_FIRST : KEY_SECOND));
        if (kind == 5) rchk(STATUS_OFS, 32'h02, 32'h02, "armed");
        wr(CONTROL_OFS, kind == 3 ? 32'h02 : 32'h82);
    endtask

    initial begin
        repeat (50000) @(posedge clock);
        n_mismatch++;
        $display("Error at %0t: run too long", $time);
        close_out();
    end

    initial begin
        logic [31:0] r;
        logic e;
        int k;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        check(32'({coreStall, flashErase, flashProgram, flashRead, pslverr}), 32'h0, "reset");
        check(prdata, 32'h0, "reset prdata");
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, r, e);
            check(32'(e), 32'(rows[i].e), "write err");
            apb(1'b0, rows[i].a, 32'h0, r, e);
            check(r, rows[i].q, "readback");
            check(32'(e), 32'(rows[i].e), "read err");
        end
        // Array read loads the data registers
        wr(ADDR_LOW_OFS, 32'h23);
        wr(ADDR_HIGH_OFS, 32'h01);
        wr(CONTROL_OFS, 32'h01);
        k = 0;
        do begin
            apb(1'b0, CONTROL_OFS, 32'h0, r, e);
            k++;
        end while (r[CTRL_READ_BIT] !== 1'b0 && k < 10);
        if (r[CTRL_READ_BIT] !== 1'b0) begin
            n_mismatch++;
            $display("Error at %0t: array read never finished", $time);
            close_out();
        end
        rchk(DATA_LOW_OFS, 32'hff, 32'h79, "read low");
        rchk(DATA_HIGH_OFS, 32'h3f, 32'h2b, "read high");
        for (int kd = 1; kd <= 5; kd++) begin
            seq(13'h0200, 14'h1111, kd);
            rchk(STATUS_OFS, 32'h1c, 32'h10, "bad unlock");
        end
        seq(13'h0201, 14'h1111, 0);
        rchk(STATUS_OFS, 32'h1c, 32'h10, "wrong index");
        for (int i = 0; i < 4; i++) begin
            if (i == 1) begin
                seq(13'h0205, 14'h0777, 0);
                rchk(STATUS_OFS, 32'h1c, 32'h14, "other block");
            end
            seq(13'h0200 + 13'(i), 14'h1000 + 14'(i * 3), 0);
            if (i < 3) begin
                check(32'(stallCnt + nProg + nErase), 32'h0, "no stall");
                rchk(STATUS_OFS, 32'h1c, 32'(i + 1) << 2, "index");
                rchk(CONTROL_OFS, 32'h02, 32'h0, "trigger clear");
            end
        end
        repeat (2) begin
            @(negedge clock);
            check(32'(coreStall), 32'h0, "setup stall");
        end
        rchk(STATUS_OFS, 32'h01, 32'h01, "busy in stall");
        rchk(CONTROL_OFS, 32'h02, 32'h02, "trigger busy");
        k = 0;
        while ((coreStall !== 1'b0 || nProg < 4) && k < 200) begin
            @(negedge clock);
            k++;
        end
        if (k >= 200) begin
            n_mismatch++;
            $display("Error at %0t: block write never finished", $time);
            close_out();
        end
        check(32'(nErase), 32'h1, "erase count");
        check(32'(eraseAddr), 32'h0200, "erase addr");
        check(32'(nProg), 32'h4, "program count");
        for (int i = 0; i < 4; i++) begin
            check(32'(progAddr[i]), 32'h0200 + 32'(i), "prog addr");
            check(32'(progData[i]), 32'h1000 + 32'(i * 3), "prog data");
        end
        check(32'(stallCnt >= WC + 4 && stallCnt <= WC + 5), 32'h1, "stall length");
        rchk(STATUS_OFS, 32'h1f, 32'h0, "done");
        rchk(CONTROL_OFS, 32'h02, 32'h0, "trigger done");
        foreach (wps[i]) begin
            reset <= 1'b1;
            writeProtectSelect <= wps[i].sel;
            repeat (2) @(posedge clock);
            reset <= 1'b0;
            seq(wps[i].addr, 14'h0abc, 0);
            rchk(STATUS_OFS, 32'h1c, wps[i].q, "protect");
        end
        close_out();
    end
endmodule
